// ==== rtl/uart_data_buffer_baud_select.v ====
// Purpose: serial data buffer, frame engine and baud source behind AXI4-Lite
// Assumes: 100 MHz core clock, synchronous active-low reset, 32-bit data bus
// Notes:   transmit bytes queue in an 8-word FIFO; a full FIFO stalls the write
`include "uart_regs.vh"
module uart_data_buffer_baud_select #(
	parameter FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire        core_clk_in,
	input  wire        rst_n_in,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// Serial pins
	input  wire        rxd_in,
	output reg         txd_out,
	input  wire        external_clock_input_in
);
	localparam TX_IDLE  = 2'h0;
	localparam TX_START = 2'h1;
	localparam TX_DATA  = 2'h2;
	localparam TX_STOP  = 2'h3;
	localparam RX_IDLE  = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_DATA  = 2'h2;
	localparam RX_STOP  = 2'h3;
	localparam [7:0] CTL_RESET = `RST_CONTROL;

	function [9:0] reg_index;
		input [11:0] addr;
		begin
			reg_index = addr[11:2];
		end
	endfunction

	// Bus state
	reg        aw_have_q;
	reg [9:0]  waddr_q;
	reg        w_have_q;
	reg [7:0]  wdata_q;
	reg        wstrb0_q;
	// Control and status
	reg        frame_length_select_q;
	reg        rx_enable_q;
	reg        tx_ninth_bit_q;
	reg        rx_ninth_bit_q;
	reg        tx_done_flag_q;
	reg        tx_done_flag_d;
	reg        rx_done_flag_q;
	reg        rx_done_flag_d;
	reg        timer1_clock_select_q;
	reg [1:0]  timer_prescale_select_q;
	reg [7:0]  reload_q;
	reg [7:0]  rx_latch_q;
	// Frame engines
	reg [1:0]  tx_state_q;
	reg [8:0]  tx_shift_q;
	reg [3:0]  tx_cnt_q;
	reg        tx_half_q;
	reg        tx_set;
	reg [1:0]  rx_state_q;
	reg [8:0]  rx_shift_q;
	reg [3:0]  rx_cnt_q;
	reg        rx_half_q;
	reg        rx_set;
	reg [2:0]  rx_sync_q;
	reg        rx_level_q;
	reg [7:0]  ctl_read;
	reg [31:0] rd_word;
	reg [1:0]  rd_resp;

	wire       ovf;
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [8:0] fifo_out_data;
	wire       fifo_pop;
	wire [3:0] last_bit;
	wire       is_dbuf;
	wire       is_ctl;
	wire       is_tcfg;
	wire       is_reload;
	wire       wr_go;
	wire       wr_ctl;

	assign is_dbuf   = (waddr_q == `IDX_SERIAL_DATA_BUFFER);
	assign is_ctl    = (waddr_q == `IDX_SERIAL_PORT_CONTROL);
	assign is_tcfg   = (waddr_q == `IDX_TIMER_CLOCK_CONFIG);
	assign is_reload = (waddr_q == `IDX_TIMER_RELOAD);
	// Full FIFO holds the write off instead of dropping the byte
	assign wr_go     = aw_have_q & w_have_q & ~s_axi_bvalid_out &
		(~is_dbuf | ~wstrb0_q | fifo_in_ready);
	assign wr_ctl    = wr_go & is_ctl & wstrb0_q;
	assign fifo_pop  = (tx_state_q == TX_IDLE) & fifo_out_valid;
	assign last_bit  = frame_length_select_q ? 4'h8 : 4'h7;

	tx_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_tx_fifo (
		.core_clk_in   (core_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (wr_go & is_dbuf & wstrb0_q),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({tx_ninth_bit_q & frame_length_select_q, wdata_q}),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_out_data)
	);

	baud_timer u_baud_timer (
		.core_clk_in              (core_clk_in),
		.rst_n_in                 (rst_n_in),
		.timer1_clock_select_in   (timer1_clock_select_q),
		.timer_prescale_select_in (timer_prescale_select_q),
		.reload_in                (reload_q),
		.external_clock_input_in  (external_clock_input_in),
		.ovf_out                  (ovf)
	);

	// Hardware set wins over a software clear in the same cycle
	always @*
	begin
		tx_done_flag_d = tx_set | (wr_ctl ? wdata_q[`CTL_TX_DONE_BIT] : tx_done_flag_q);
		rx_done_flag_d = rx_set | (wr_ctl ? wdata_q[`CTL_RX_DONE_BIT] : rx_done_flag_q);
	end

	always @*
	begin
		ctl_read = 8'h00;
		ctl_read[`CTL_FRAME_LENGTH_BIT] = frame_length_select_q;
		ctl_read[`CTL_RX_ENABLE_BIT]    = rx_enable_q;
		ctl_read[`CTL_TX_NINTH_BIT]     = tx_ninth_bit_q;
		ctl_read[`CTL_RX_NINTH_BIT]     = rx_ninth_bit_q;
		ctl_read[`CTL_TX_DONE_BIT]      = tx_done_flag_q;
		ctl_read[`CTL_RX_DONE_BIT]      = rx_done_flag_q;
		rd_resp = `RESP_OKAY;
		case (reg_index(s_axi_araddr_in))
			`IDX_SERIAL_PORT_CONTROL: rd_word = {24'h000000, ctl_read};
			`IDX_SERIAL_DATA_BUFFER:  rd_word = {24'h000000, rx_latch_q};
			`IDX_TIMER_CLOCK_CONFIG:  rd_word = {28'h0000000, timer1_clock_select_q,
				1'b0, timer_prescale_select_q};
			`IDX_TIMER_RELOAD:        rd_word = {24'h000000, reload_q};
			default:
			begin
				rd_word = 32'h00000000;
				rd_resp = `RESP_SLVERR;
			end
		endcase
	end

	// Bus slave
	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `RESP_OKAY;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rresp_out   <= `RESP_OKAY;
			s_axi_rdata_out   <= 32'h00000000;
			aw_have_q         <= 1'b0;
			waddr_q           <= 10'h000;
			w_have_q          <= 1'b0;
			wdata_q           <= `RST_DATA_BUFFER;
			wstrb0_q          <= 1'b0;
		end
		else
		begin
			s_axi_awready_out <= s_axi_awvalid_in & ~s_axi_awready_out & ~aw_have_q;
			if (s_axi_awvalid_in & s_axi_awready_out)
			begin
				aw_have_q <= 1'b1;
				waddr_q   <= reg_index(s_axi_awaddr_in);
			end
			s_axi_wready_out <= s_axi_wvalid_in & ~s_axi_wready_out & ~w_have_q;
			if (s_axi_wvalid_in & s_axi_wready_out)
			begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata_in[7:0];
				wstrb0_q <= s_axi_wstrb_in[0];
			end
			if (wr_go)
			begin
				aw_have_q        <= 1'b0;
				w_have_q         <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= (is_dbuf | is_ctl | is_tcfg | is_reload) ?
					`RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
			s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
			if (s_axi_arvalid_in & s_axi_arready_out)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out  <= rd_word;
				s_axi_rresp_out  <= rd_resp;
			end
			else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// Software registers
	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			frame_length_select_q   <= CTL_RESET[`CTL_FRAME_LENGTH_BIT];
			rx_enable_q             <= 1'b0;
			tx_ninth_bit_q          <= 1'b0;
			rx_ninth_bit_q          <= 1'b0;
			tx_done_flag_q          <= 1'b0;
			rx_done_flag_q          <= 1'b0;
			timer1_clock_select_q   <= 1'b0;
			timer_prescale_select_q <= 2'h0;
			reload_q                <= `RST_TIMER_RELOAD;
		end
		else
		begin
			tx_done_flag_q <= tx_done_flag_d;
			rx_done_flag_q <= rx_done_flag_d;
			if (wr_ctl)
			begin
				frame_length_select_q <= wdata_q[`CTL_FRAME_LENGTH_BIT];
				rx_enable_q           <= wdata_q[`CTL_RX_ENABLE_BIT];
				tx_ninth_bit_q        <= wdata_q[`CTL_TX_NINTH_BIT];
			end
			if (rx_set)
				rx_ninth_bit_q <= frame_length_select_q ? rx_shift_q[8] : rx_level_q;
			else if (wr_ctl)
				rx_ninth_bit_q <= wdata_q[`CTL_RX_NINTH_BIT];
			if (wr_go & is_tcfg & wstrb0_q)
			begin
				timer1_clock_select_q   <= wdata_q[`TCFG_CLOCK_SEL_BIT];
				timer_prescale_select_q <= wdata_q[`TCFG_PRESCALE_LSB +: 2];
			end
			if (wr_go & is_reload & wstrb0_q)
				reload_q <= wdata_q;
		end
	end

	// Transmitter
	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			tx_state_q <= TX_IDLE;
			tx_shift_q <= 9'h000;
			tx_cnt_q   <= 4'h0;
			tx_half_q  <= 1'b0;
			tx_set     <= 1'b0;
			txd_out    <= 1'b1;
		end
		else
		begin
			tx_set <= 1'b0;
			if (ovf)
				tx_half_q <= ~tx_half_q;
			case (tx_state_q)
				TX_IDLE:
				begin
					if (fifo_pop)
					begin
						tx_shift_q <= fifo_out_data;
						tx_cnt_q   <= 4'h0;
						tx_half_q  <= 1'b0;
						txd_out    <= 1'b0;
						tx_state_q <= TX_START;
					end
				end
				TX_START:
				begin
					if (ovf & tx_half_q)
					begin
						txd_out    <= tx_shift_q[0];
						tx_state_q <= TX_DATA;
					end
				end
				TX_DATA:
				begin
					if (ovf & tx_half_q)
					begin
						if (tx_cnt_q == last_bit)
						begin
							txd_out    <= 1'b1;
							tx_set     <= 1'b1;
							tx_state_q <= TX_STOP;
						end
						else
						begin
							tx_shift_q <= {1'b0, tx_shift_q[8:1]};
							txd_out    <= tx_shift_q[1];
							tx_cnt_q   <= tx_cnt_q + 4'h1;
						end
					end
				end
				TX_STOP:
				begin
					if (ovf & tx_half_q)
						tx_state_q <= TX_IDLE;
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// Receiver; start is checked one overflow in, then sampled every two
	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			rx_sync_q  <= 3'h7;
			rx_level_q <= 1'b1;
			rx_state_q <= RX_IDLE;
			rx_shift_q <= 9'h000;
			rx_cnt_q   <= 4'h0;
			rx_half_q  <= 1'b0;
			rx_set     <= 1'b0;
			rx_latch_q <= `RST_DATA_BUFFER;
		end
		else
		begin
			rx_sync_q <= {rx_sync_q[1:0], rxd_in};
			if (rx_sync_q[1] == rx_sync_q[2])
				rx_level_q <= rx_sync_q[2];
			rx_set <= 1'b0;
			if (ovf)
				rx_half_q <= ~rx_half_q;
			case (rx_state_q)
				RX_IDLE:
				begin
					if (rx_enable_q & ~rx_level_q)
					begin
						rx_state_q <= RX_START;
						rx_half_q  <= 1'b0;
					end
				end
				RX_START:
				begin
					if (ovf)
					begin
						rx_half_q  <= 1'b0;
						rx_cnt_q   <= 4'h0;
						rx_state_q <= rx_level_q ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (ovf & rx_half_q)
					begin
						rx_shift_q <= {rx_level_q, rx_shift_q[8:1]};
						rx_cnt_q   <= rx_cnt_q + 4'h1;
						if (rx_cnt_q == last_bit)
							rx_state_q <= RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (ovf & rx_half_q)
					begin
						rx_latch_q <= frame_length_select_q ? rx_shift_q[7:0] :
							rx_shift_q[8:1];
						rx_set     <= 1'b1;
						rx_state_q <= RX_IDLE;
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end
endmodule

// ==== rtl/uart_regs.vh ====
// Purpose: register map, field positions, reset values and divide counts
// Assumes: word-indexed map, byte address is four times the index
// Notes:   definitions only
`ifndef UART_REGS_VH
`define UART_REGS_VH

`define IDX_SERIAL_PORT_CONTROL 10'h098
`define IDX_SERIAL_DATA_BUFFER  10'h099
`define IDX_TIMER_CLOCK_CONFIG  10'h09A
`define IDX_TIMER_RELOAD        10'h09B

`define CTL_FRAME_LENGTH_BIT 7
`define CTL_RX_ENABLE_BIT    4
`define CTL_TX_NINTH_BIT     3
`define CTL_RX_NINTH_BIT     2
`define CTL_TX_DONE_BIT      1
`define CTL_RX_DONE_BIT      0

`define TCFG_PRESCALE_LSB    0
`define TCFG_CLOCK_SEL_BIT   3

`define RST_DATA_BUFFER      8'h00
`define RST_CONTROL          8'h00
`define RST_TIMER_CONFIG     8'h00
`define RST_TIMER_RELOAD     8'h00

`define PRESCALE_DIV_12      2'h0
`define PRESCALE_DIV_4       2'h1
`define PRESCALE_DIV_48      2'h2
`define PRESCALE_EXT_8       2'h3
`define DIV_12_COUNT         6'h0B
`define DIV_4_COUNT          6'h03
`define DIV_48_COUNT         6'h2F
`define EXT_8_COUNT          6'h07

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== rtl/tx_fifo.v ====
// Purpose: small synchronous FIFO in the transmit data path
// Assumes: one clock, synchronous active-low reset
// Notes:   head word and valid are registered; valid drops the cycle after a pop
module tx_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             core_clk_in,
	input  wire             rst_n_in,
	// Fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// Drain side
	output reg              out_valid_out,
	input  wire             out_ready_in,
	output reg  [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wptr_q;
	reg [AW-1:0]    rptr_q;
	reg [AW:0]      count_q;
	wire            push;
	wire            pop;

	assign in_ready_out = (count_q != DEPTH[AW:0]);
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;

	always @(posedge core_clk_in)
	begin
		if (push)
			mem_q[wptr_q] <= in_data_in;
	end

	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			wptr_q        <= {AW{1'b0}};
			rptr_q        <= {AW{1'b0}};
			count_q       <= {(AW+1){1'b0}};
			out_valid_out <= 1'b0;
			out_data_out  <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
			// Lag by one cycle so a pop is never seen twice
			out_valid_out <= (count_q != {(AW+1){1'b0}}) && !pop;
			out_data_out  <= mem_q[rptr_q];
		end
	end
endmodule

// ==== rtl/baud_timer.v ====
// Purpose: prescaler and 8-bit auto-reload timer giving overflow pulses
// Assumes: external clock is far slower than the core clock
// Notes:   ovf_out is one core cycle wide
`include "uart_regs.vh"
module baud_timer (
	// Clock and reset
	input  wire       core_clk_in,
	input  wire       rst_n_in,
	// Configuration
	input  wire       timer1_clock_select_in,
	input  wire [1:0] timer_prescale_select_in,
	input  wire [7:0] reload_in,
	// External clock pin
	input  wire       external_clock_input_in,
	// Overflow
	output reg        ovf_out
);
	reg  [2:0] ext_sync_q;
	reg        ext_level_q;
	reg        ext_rise_q;
	reg  [5:0] pre_cnt_q;
	reg  [5:0] pre_top;
	reg  [7:0] timer_q;
	wire       pre_tick;
	wire       pre_step;
	wire       tick;

	always @*
	begin
		case (timer_prescale_select_in)
			`PRESCALE_DIV_12: pre_top = `DIV_12_COUNT;
			`PRESCALE_DIV_4:  pre_top = `DIV_4_COUNT;
			`PRESCALE_DIV_48: pre_top = `DIV_48_COUNT;
			default:          pre_top = `EXT_8_COUNT;
		endcase
	end

	assign pre_step = (timer_prescale_select_in == `PRESCALE_EXT_8) ? ext_rise_q : 1'b1;
	assign pre_tick = pre_step && (pre_cnt_q >= pre_top);
	assign tick     = timer1_clock_select_in ? 1'b1 : pre_tick;

	always @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			ext_sync_q  <= 3'h0;
			ext_level_q <= 1'b0;
			ext_rise_q  <= 1'b0;
			pre_cnt_q   <= 6'h00;
			timer_q     <= 8'h00;
			ovf_out     <= 1'b0;
		end
		else
		begin
			ext_sync_q <= {ext_sync_q[1:0], external_clock_input_in};
			ext_rise_q <= 1'b0;
			if (ext_sync_q[1] == ext_sync_q[2])
			begin
				ext_level_q <= ext_sync_q[2];
				ext_rise_q  <= ext_sync_q[2] & ~ext_level_q;
			end
			if (pre_tick)
				pre_cnt_q <= 6'h00;
			else if (pre_step)
				pre_cnt_q <= pre_cnt_q + 6'h01;
			ovf_out <= 1'b0;
			if (tick)
			begin
				// 256 minus reload ticks per overflow
				if (timer_q == 8'hFF)
				begin
					timer_q <= reload_in;
					ovf_out <= 1'b1;
				end
				else
					timer_q <= timer_q + 8'h01;
			end
		end
	end
endmodule

// ==== testbench/uart_props.sv ====
// Purpose: port-level checks of the serial data buffer block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the top module
`include "uart_regs.vh"
module uart_props #(
	parameter FIFO_DEPTH = 8
) (
	input wire        core_clk_in,
	input wire        rst_n_in,
	input wire        s_axi_awvalid_in,
	input wire        s_axi_awready_out,
	input wire        s_axi_wvalid_in,
	input wire        s_axi_wready_out,
	input wire [1:0]  s_axi_bresp_out,
	input wire        s_axi_bvalid_out,
	input wire        s_axi_bready_in,
	input wire [11:0] s_axi_araddr_in,
	input wire        s_axi_arvalid_in,
	input wire        s_axi_arready_out,
	input wire [31:0] s_axi_rdata_out,
	input wire [1:0]  s_axi_rresp_out,
	input wire        s_axi_rvalid_out,
	input wire        s_axi_rready_in,
	input wire        txd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	reg  aw_q;
	reg  w_q;
	wire unmapped;
	assign unmapped = s_axi_araddr_in[11:2] < `IDX_SERIAL_PORT_CONTROL ||
		s_axi_araddr_in[11:2] > `IDX_TIMER_RELOAD;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Remembers which halves of the current write were taken
	always @(posedge core_clk_in)
	begin
		if (!rst_n_in || (s_axi_bvalid_out && s_axi_bready_in))
		begin
			aw_q <= 1'b0;
			w_q  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
				aw_q <= 1'b1;
			if (s_axi_wvalid_in && s_axi_wready_out)
				w_q <= 1'b1;
		end
	end
	a_aw_pulse: assert property (s_axi_awready_out |=> !s_axi_awready_out)
		else $error("awready longer than one cycle");
	a_w_pulse: assert property (s_axi_wready_out |=> !s_axi_wready_out)
		else $error("wready longer than one cycle");
	a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address taken while read data pending");
	a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	a_b_after_both: assert property ($rose(s_axi_bvalid_out) |-> aw_q && w_q)
		else $error("write response before address and data");
	a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	a_r_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out && unmapped |=>
		s_axi_rresp_out == `RESP_SLVERR && s_axi_rdata_out == 32'h0)
		else $error("unmapped read not refused");
	a_txd_idle: assert property ($rose(rst_n_in) |-> txd_out)
		else $error("serial line not idle after reset");
	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
	c_frame: cover property ($fell(txd_out));
endmodule
bind uart_data_buffer_baud_select uart_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .txd_out(txd_out));

// ==== testbench/uart_peer.sv ====
// Purpose: remote serial transceiver on the line side
// Assumes: bit length in core cycles is set by the bench before each frame
// Notes:   samples mid-bit, so a bit shorter than half its length is missed
module uart_peer (
	input  wire core_clk_in,
	input  wire txd_in,
	output reg  rxd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bit_cyc = 32;
	bit         nine;
	int         cyc;
	int         t_fall;
	int         low_len;
	int         frames;
	logic [8:0] got;
	logic       stop;
	initial rxd_out = 1'b1;
	always @(posedge core_clk_in) cyc <= cyc + 1;
	always @(posedge txd_in) low_len = cyc - t_fall;
	initial
	forever
	begin
		@(negedge txd_in);
		t_fall = cyc;
		got = 9'h000;
		repeat (bit_cyc / 2) @(posedge core_clk_in);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			repeat (bit_cyc) @(posedge core_clk_in);
			got[i] = txd_in;
		end
		repeat (bit_cyc) @(posedge core_clk_in);
		stop = txd_in;
		frames++;
	end
	// Line returns to the idle mark level after the stop bit
	task automatic send_frame(input logic [8:0] d);
		rxd_out <= 1'b0;
		repeat (bit_cyc) @(posedge core_clk_in);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			rxd_out <= d[i];
			repeat (bit_cyc) @(posedge core_clk_in);
		end
		rxd_out <= 1'b1;
		repeat (bit_cyc) @(posedge core_clk_in);
	endtask
endmodule

// ==== testbench/tb.sv ====
// Purpose: register-level tests of the serial data buffer block
// Assumes: 100 MHz core clock, external clock at one tenth of it
// Notes:   short bit lengths come from reload values near 0xFF
`include "uart_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [11:0] A_CTL = {`IDX_SERIAL_PORT_CONTROL, 2'b00};
	localparam [11:0] A_BUF = {`IDX_SERIAL_DATA_BUFFER, 2'b00};
	localparam [11:0] A_CFG = {`IDX_TIMER_CLOCK_CONFIG, 2'b00};
	localparam [11:0] A_REL = {`IDX_TIMER_RELOAD, 2'b00};
	localparam [1:0]  OK = `RESP_OKAY;
	localparam [1:0]  ERR = `RESP_SLVERR;
	logic        clk, rst_n, awv, wv, bready, arv, rready, ext;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	wire         awready, wready, bvalid, arready, rvalid, txd, rxd;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	int          fails, checks_done, cyc, n;
	logic [7:0]  cfg[5] = '{8'h0A, 8'h00, 8'h01, 8'h02, 8'h03};
	logic [7:0]  rel[5] = '{8'hF0, 8'hFC, 8'hFC, 8'hFC, 8'hFC};
	int          bits[5] = '{32, 96, 32, 384, 640};
	uart_data_buffer_baud_select #(.FIFO_DEPTH(8)) i_dut (
		.core_clk_in(clk), .rst_n_in(rst_n),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.rxd_in(rxd), .txd_out(txd), .external_clock_input_in(ext));
	uart_peer p (.core_clk_in(clk), .txd_in(txd), .rxd_out(rxd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_time(input int got, input int exp, input int tol);
		checks_done++;
		if (got < exp - tol || got > exp + tol)
		begin
			fails++;
			$display("wrong value at %0t: length %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		do
		begin
			@(posedge clk);
			if (!aw && awready)
			begin
				aw = 1;
				awv <= 0;
			end
			if (!w && wready)
			begin
				w = 1;
				wv <= 0;
			end
		end while (!bvalid);
		bready <= 1;
		@(posedge clk);
		bready <= 0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar;
		ar = 0;
		araddr <= a;
		arv <= 1;
		do
		begin
			@(posedge clk);
			if (!ar && arready)
			begin
				ar = 1;
				arv <= 0;
			end
		end while (!rvalid);
		rready <= 1;
		@(posedge clk);
		rready <= 0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic wait_fr(input int k);
		while (p.frames < k)
			@(posedge clk);
	endtask
	task final_report;
		$display("checks %0d failures %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// External clock free-runs out of phase with the core clock
	initial
	begin
		ext = 0;
		#3;
		forever #50 ext = ~ext;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			final_report;
		end
	end
	initial
	begin
		{rst_n, awv, wv, bready, arv, rready} = 6'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd(A_BUF, 32'h0, OK);
		rd(A_CTL, 32'h0, OK);
		rd(12'h000, 32'h0, ERR);
		wr(12'h004, 8'h55, ERR);
		for (int k = 0; k < 5; k++)
		begin
			wr(A_CFG, cfg[k], OK);
			wr(A_REL, rel[k], OK);
			p.bit_cyc = bits[k];
			n = p.frames;
			// The old count must overflow before the new rate applies, so the
			// first frame may have a long start bit; the second one is timed
			wr(A_BUF, 8'h00, OK);
			wr(A_BUF, 8'h00, OK);
			wait_fr(n + 2);
			chk_time(p.low_len, 9 * bits[k], bits[k] / 2);
			chk({23'h0, p.got}, 32'h0);
		end
		wr(A_CFG, 8'h0A, OK);
		wr(A_REL, 8'hF0, OK);
		p.bit_cyc = 32;
		wr(A_CTL, 8'h10, OK);
		n = p.frames;
		wr(A_BUF, 8'hA5, OK);
		wait_fr(n + 1);
		chk({23'h0, p.got}, 32'hA5);
		chk({31'h0, p.stop}, 32'h1);
		rd(A_CTL, 32'h12, OK);
		wr(A_CTL, 8'h10, OK);
		rd(A_CTL, 32'h10, OK);
		p.send_frame(9'h03C);
		rd(A_BUF, 32'h3C, OK);
		rd(A_CTL, 32'h15, OK);
		wr(A_CTL, 8'h98, OK);
		p.nine = 1;
		n = p.frames;
		wr(A_BUF, 8'h5A, OK);
		wait_fr(n + 1);
		chk({23'h0, p.got}, 32'h15A);
		rd(A_CTL, 32'h9A, OK);
		wr(A_CTL, 8'h90, OK);
		p.send_frame(9'h0C3);
		rd(A_BUF, 32'hC3, OK);
		rd(A_CTL, 32'h91, OK);
		wr(A_CTL, 8'h10, OK);
		p.nine = 0;
		n = p.frames;
		// Ten back-to-back bytes overrun the queue, so the last write stalls
		for (int i = 0; i < 10; i++)
			wr(A_BUF, 8'(i * 17), OK);
		wait_fr(n + 10);
		chk({23'h0, p.got}, 32'h99);
		final_report;
	end
endmodule
